/* File: hdl/pgo_pkg.sv */
// constants of the eight-pin open-drain capable port
// assumes a 32-bit axi4-lite register bus with 16-bit addresses
package pgo_pkg;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 32;
  localparam int PINS   = 8;

  // ****************************************************************
  // register indices as printed, byte address is four times index
  // ****************************************************************
  localparam logic [ADDR_W-1:0] IDX_LATCH    = 16'h0004;
  localparam logic [ADDR_W-1:0] IDX_OPENDR   = 16'h1F84;
  localparam logic [ADDR_W-1:0] IDX_DIR      = 16'h1F8A;
  localparam logic [ADDR_W-1:0] IDX_RMW_VIEW = 16'h0040;
  localparam logic [ADDR_W-1:0] ADDR_LATCH    = IDX_LATCH << 2;
  localparam logic [ADDR_W-1:0] ADDR_OPENDR   = IDX_OPENDR << 2;
  localparam logic [ADDR_W-1:0] ADDR_DIR      = IDX_DIR << 2;
  localparam logic [ADDR_W-1:0] ADDR_RMW_VIEW = IDX_RMW_VIEW << 2;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [PINS-1:0] RST_LATCH  = 8'h00;
  localparam logic [PINS-1:0] RST_OPENDR = 8'h00;
  localparam logic [PINS-1:0] RST_DIR    = 8'h00;

  // ****************************************************************
  // alternate function bit positions
  // ****************************************************************
  localparam int BIT_WIDE_TIMER_PIN   = 7;
  localparam int BIT_PULSE_OUTPUT_TWO = 6;
  localparam int BIT_UART_TRANSMIT    = 5;
  localparam int BIT_UART_RECEIVE     = 4;
  localparam int BIT_SERIAL_CLOCK     = 3;
  localparam int BIT_MOTOR_PHASE_U    = 2;
  localparam int BIT_MOTOR_PHASE_V    = 1;
  localparam int BIT_MOTOR_PHASE_W    = 0;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* File: hdl/pgo_addr_decode.sv */
// address decoder for the port registers
// assumes word-aligned byte addresses from the bus slave
`timescale 1ns/100ps
module pgo_addr_decode
  import pgo_pkg::*;
(
  input  wire logic [pgo_pkg::ADDR_W-1:0] addr,
  output wire logic                        selLatch,
  output wire logic                        selOpenDr,
  output wire logic                        selDir,
  output wire logic                        selRmw,
  output wire logic                        hit
);
  assign selLatch  = (addr == ADDR_LATCH);
  assign selOpenDr = (addr == ADDR_OPENDR);
  assign selDir    = (addr == ADDR_DIR);
  assign selRmw    = (addr == ADDR_RMW_VIEW);
  assign hit       = selLatch | selOpenDr | selDir | selRmw;
endmodule

/* File: hdl/pgo_pad_logic.sv */
// per-pin drive and readback logic of the port
// assumes pin levels synchronous to the system clock
`timescale 1ns/100ps
module pgo_pad_logic
  import pgo_pkg::*;
(
  input  wire logic [pgo_pkg::PINS-1:0] latch,
  input  wire logic [pgo_pkg::PINS-1:0] dir,
  input  wire logic [pgo_pkg::PINS-1:0] openDr,
  input  wire logic [pgo_pkg::PINS-1:0] pinIn,
  input  wire logic                      oscFail,
  output wire logic [pgo_pkg::PINS-1:0] drvOut,
  output wire logic [pgo_pkg::PINS-1:0] drvOe,
  output wire logic [pgo_pkg::PINS-1:0] readPlain,
  output wire logic [pgo_pkg::PINS-1:0] readRmw
);
  genvar i;
  generate
    for (i = 0; i < PINS; i++)
    begin : g_pin
      wire logic pushOut;
      // push-pull output reads its latch, every other mode the pin
      assign pushOut      = ~openDr[i] & dir[i];
      assign drvOut[i]    = ~openDr[i] & latch[i];
      assign drvOe[i]     = ~oscFail &
                            (openDr[i] ? ~latch[i] : dir[i]);
      assign readPlain[i] = pushOut ? latch[i] : pinIn[i];
      assign readRmw[i]   = openDr[i] ? latch[i] : readPlain[i];
    end
  endgenerate
endmodule

/* File: hdl/pgo_port.sv */
// top of the eight-pin port with axi4-lite register access
// assumes pins synchronous to sys_clk and an outside pad resolving
// pinOut and pinOe into the wire level returned on pinIn
//
// Overview of operation
// - eight pins, each direction bit in push-pull mode: 0 input, 1 output, ignored in open drain
// - reset clears the direction register, all pins input
// - reset clears all eight output latch bits
// - per-pin open-drain select: 0 push-pull, 1 open-drain
// - reset clears the open-drain select register
// - oscillation failure reset releases every pin to high impedance
// - push-pull input mode: pin undriven, read returns pin level
// - push-pull output mode: pin drives latch, read returns latch
// - open-drain with latch 0: pin driven low, read returns pin
// - open-drain with latch 1: pin released, read returns pin
// - peripheral input equals the software read value of each pin
// - open-drain read-modify-write reads latch, other pins read as in a plain read
// - alternate functions: 7 timer, 6 pulse, 5..3 serial, 2..0 motor
`timescale 1ns/100ps
module pgo_port
  import pgo_pkg::*;
(
  input  wire logic                        sys_clk,
  input  wire logic                        reset_n,
  input  wire logic [pgo_pkg::ADDR_W-1:0]  s_axi_awaddr,
  input  wire logic [2:0]                  s_axi_awprot,
  input  wire logic                        s_axi_awvalid,
  output logic                             s_axi_awready,
  input  wire logic [pgo_pkg::DATA_W-1:0]  s_axi_wdata,
  input  wire logic [3:0]                  s_axi_wstrb,
  input  wire logic                        s_axi_wvalid,
  output logic                             s_axi_wready,
  output logic [1:0]                       s_axi_bresp,
  output logic                             s_axi_bvalid,
  input  wire logic                        s_axi_bready,
  input  wire logic [pgo_pkg::ADDR_W-1:0]  s_axi_araddr,
  input  wire logic [2:0]                  s_axi_arprot,
  input  wire logic                        s_axi_arvalid,
  output logic                             s_axi_arready,
  output logic [pgo_pkg::DATA_W-1:0]       s_axi_rdata,
  output logic [1:0]                       s_axi_rresp,
  output logic                             s_axi_rvalid,
  input  wire logic                        s_axi_rready,
  input  wire logic                        oscillation_failure_reset,
  input  wire logic [pgo_pkg::PINS-1:0]    pinIn,
  output logic [pgo_pkg::PINS-1:0]         pinOut,
  output logic [pgo_pkg::PINS-1:0]         pinOe,
  output logic [pgo_pkg::PINS-1:0]         periphIn
);
  import pgo_pkg::*;

  // ****************************************************************
  // state
  // ****************************************************************
  logic [PINS-1:0]   latch_reg, latch_next;
  logic [PINS-1:0]   openDr_reg, openDr_next;
  logic [PINS-1:0]   dir_reg, dir_next;
  logic [ADDR_W-1:0] awAddr_reg;
  logic [7:0]        wByte_reg;
  logic              wLane_reg;
  logic              awHeld_reg, wHeld_reg;
  logic              awready_reg, wready_reg, bvalid_reg;
  logic [1:0]        bresp_reg;
  logic              arready_reg, rvalid_reg;
  logic [1:0]        rresp_reg;
  logic [DATA_W-1:0] rdata_reg;
  logic [PINS-1:0]   pinOut_reg, pinOe_reg, periph_reg;

  // ****************************************************************
  // write channel decode
  // ****************************************************************
  wire logic              awFire;
  wire logic              wFire;
  wire logic              awHave;
  wire logic              wHave;
  wire logic [ADDR_W-1:0] wrAddr;
  wire logic [7:0]        wrByte;
  wire logic              wrLane;
  wire logic              doWrite;
  wire logic              wSelLatch, wSelOpenDr, wSelDir, wSelRmw, wHit;

  assign awFire  = s_axi_awvalid & awready_reg;
  assign wFire   = s_axi_wvalid & wready_reg;
  assign awHave  = awHeld_reg | awFire;
  assign wHave   = wHeld_reg | wFire;
  assign wrAddr  = awHeld_reg ? awAddr_reg : s_axi_awaddr;
  assign wrByte  = wHeld_reg ? wByte_reg : s_axi_wdata[7:0];
  assign wrLane  = wHeld_reg ? wLane_reg : s_axi_wstrb[0];
  assign doWrite = awHave & wHave & ~bvalid_reg;

  pgo_addr_decode u_wdec
  (
    .addr      (wrAddr),
    .selLatch  (wSelLatch),
    .selOpenDr (wSelOpenDr),
    .selDir    (wSelDir),
    .selRmw    (wSelRmw),
    .hit       (wHit)
  );

  // the readback view is read only, writes there are refused
  wire logic wrOk;
  assign wrOk = wHit & ~wSelRmw;

  // next register values feed the drivers in the same edge
  assign latch_next  = (doWrite & wSelLatch & wrLane) ?
                       wrByte : latch_reg;
  assign openDr_next = (doWrite & wSelOpenDr & wrLane) ?
                       wrByte : openDr_reg;
  assign dir_next    = (doWrite & wSelDir & wrLane) ?
                       wrByte : dir_reg;

  // ****************************************************************
  // read channel decode
  // ****************************************************************
  wire logic              arFire;
  wire logic              rSelLatch, rSelOpenDr, rSelDir, rSelRmw, rHit;
  wire logic [PINS-1:0]   readPlain, readRmw;
  wire logic [PINS-1:0]   rdByte;
  wire logic [DATA_W-1:0] rdWord;

  assign arFire = s_axi_arvalid & arready_reg;

  pgo_addr_decode u_rdec
  (
    .addr      (s_axi_araddr),
    .selLatch  (rSelLatch),
    .selOpenDr (rSelOpenDr),
    .selDir    (rSelDir),
    .selRmw    (rSelRmw),
    .hit       (rHit)
  );

  pgo_pad_logic u_rdpad
  (
    .latch     (latch_reg),
    .dir       (dir_reg),
    .openDr    (openDr_reg),
    .pinIn     (pinIn),
    .oscFail   (oscillation_failure_reset),
    .drvOut    (),
    .drvOe     (),
    .readPlain (readPlain),
    .readRmw   (readRmw)
  );

  // plain reads sample pins except push-pull outputs, which return latch; the rmw view returns latch in open drain
  assign rdByte = ({PINS{rSelLatch}}  & readPlain)  |
                  ({PINS{rSelRmw}}    & readRmw)    |
                  ({PINS{rSelOpenDr}} & openDr_reg) |
                  ({PINS{rSelDir}}    & dir_reg);
  assign rdWord = {{(DATA_W-PINS){1'b0}}, rdByte};

  // ****************************************************************
  // pin drivers from the next register values
  // ****************************************************************
  wire logic [PINS-1:0] drvOut, drvOe;

  pgo_pad_logic u_drvpad
  (
    .latch     (latch_next),
    .dir       (dir_next),
    .openDr    (openDr_next),
    .pinIn     (pinIn),
    .oscFail   (oscillation_failure_reset),
    .drvOut    (drvOut),
    .drvOe     (drvOe),
    .readPlain (),
    .readRmw   ()
  );

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      latch_reg  <= RST_LATCH;
      openDr_reg <= RST_OPENDR;
      dir_reg    <= RST_DIR;
    end
    else
    begin
      latch_reg  <= latch_next;
      openDr_reg <= openDr_next;
      dir_reg    <= dir_next;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      pinOut_reg <= '0;
      pinOe_reg  <= '0;
      periph_reg <= '0;
    end
    else
    begin
      pinOut_reg <= drvOut;
      pinOe_reg  <= drvOe;
      periph_reg <= readPlain;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      awHeld_reg  <= 1'b0;
      wHeld_reg   <= 1'b0;
      awAddr_reg  <= '0;
      wByte_reg   <= '0;
      wLane_reg   <= 1'b0;
      awready_reg <= 1'b0;
      wready_reg  <= 1'b0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= RESP_OKAY;
    end
    else
    begin
      if (awFire)
        awAddr_reg <= s_axi_awaddr;
      if (wFire)
        wByte_reg <= s_axi_wdata[7:0];
      if (wFire)
        wLane_reg <= s_axi_wstrb[0];
      awHeld_reg  <= awHave & ~doWrite;
      wHeld_reg   <= wHave & ~doWrite;
      awready_reg <= ~awHave & ~bvalid_reg & ~doWrite;
      wready_reg  <= ~wHave & ~bvalid_reg & ~doWrite;
      if (doWrite)
      begin
        bvalid_reg <= 1'b1;
        bresp_reg  <= wrOk ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bready)
        bvalid_reg <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b0;
      rresp_reg   <= RESP_OKAY;
      rdata_reg   <= '0;
    end
    else
    begin
      arready_reg <= ~rvalid_reg & ~arFire;
      if (arFire)
      begin
        rvalid_reg <= 1'b1;
        rdata_reg  <= rdWord;
        rresp_reg  <= rHit ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_rready)
        rvalid_reg <= 1'b0;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign s_axi_awready = awready_reg;
  assign s_axi_wready  = wready_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rresp   = rresp_reg;
  assign s_axi_rdata   = rdata_reg;
  assign pinOut        = pinOut_reg;
  assign pinOe         = pinOe_reg;
  // bit order follows the alternate function map
  assign periphIn      = periph_reg;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!reset_n);

  sequence s_write_to(logic sel);
    doWrite && sel && wrLane;
  endsequence

  sequence s_rmw_read;
    arFire && rSelRmw;
  endsequence

  a_dir_write: assert property (
    s_write_to(wSelDir) |=> dir_reg == $past(wrByte))
    else $error("direction register missed a write");

  a_reset_dir: assert property (
    $rose(reset_n) |-> dir_reg == RST_DIR)
    else $error("direction not clear after reset");

  a_reset_latch: assert property (
    $rose(reset_n) |-> latch_reg == RST_LATCH && pinOe == '0)
    else $error("latch or drivers not clear after reset");

  a_reset_opendr: assert property (
    $rose(reset_n) |-> openDr_reg == RST_OPENDR)
    else $error("open drain select not clear after reset");

  a_osc_fail_hiz: assert property (
    oscillation_failure_reset |=> pinOe == '0)
    else $error("pin driven during oscillation failure");

  a_input_undriven: assert property (
    (pinOe & ~openDr_reg & ~dir_reg) == '0)
    else $error("input mode pin is driven");

  a_push_output: assert property (
    !$past(oscillation_failure_reset) |->
      ((pinOut ^ latch_reg) & ~openDr_reg & dir_reg) == '0 &&
      (~pinOe & ~openDr_reg & dir_reg) == '0)
    else $error("output mode pin not driving its latch");

  a_od_low: assert property (
    !$past(oscillation_failure_reset) |->
      (~pinOe & openDr_reg & ~latch_reg) == '0 &&
      (pinOut & openDr_reg) == '0)
    else $error("open drain low not driven low");

  a_od_release: assert property (
    (pinOe & openDr_reg & latch_reg) == '0)
    else $error("open drain high is driven");

  // the first edge after reset still shows the cleared capture register
  a_periph_match: assert property (
    $past(reset_n) |->
      periphIn == $past((~openDr_reg & dir_reg & latch_reg) |
                        (~(~openDr_reg & dir_reg) & pinIn)))
    else $error("peripheral input differs from read value");

  a_rmw_view: assert property (
    s_rmw_read |=> s_axi_rvalid &&
      s_axi_rdata[7:0] == $past((openDr_reg & latch_reg) |
                                (~openDr_reg & readPlain)))
    else $error("rmw read did not return latch in open drain");

  a_write_to_pin: assert property (
    s_write_to(wSelLatch) ##1 !$past(oscillation_failure_reset) |->
      latch_reg == $past(wrByte) &&
      ((pinOut ^ latch_reg) & ~openDr_reg) == '0)
    else $error("latch write did not reach pin drivers");
endmodule

/* File: dv/pgo_pin_model.sv */
// outside circuitry on the eight port pins
// assumes a pull-up on every pin and an optional outside driver per pin
`timescale 1ns/100ps
module pgo_pin_model
  import pgo_pkg::*;
(
  input  wire logic [pgo_pkg::PINS-1:0] pinOut,
  input  wire logic [pgo_pkg::PINS-1:0] pinOe,
  input  wire logic [pgo_pkg::PINS-1:0] extOe,
  input  wire logic [pgo_pkg::PINS-1:0] extVal,
  output wire logic [pgo_pkg::PINS-1:0] pinIn
);
  import pgo_pkg::*;
  // ****************************************************************
  // wire level: port drive, else outside driver, else pull-up
  // ****************************************************************
  assign pinIn = (pinOe & pinOut) | (~pinOe & extOe & extVal)
               | (~pinOe & ~extOe);
endmodule

/* File: dv/port4_gpio_open_drain_test.sv */
// self-checking bench of the eight-pin port
// assumes the port top, its package and the pin model are compiled first
`timescale 1ns/100ps
module port4_gpio_open_drain_test;
  import pgo_pkg::*;
  logic              sys_clk = 1'b0;
  logic              reset_n = 1'b0;
  logic [15:0]       s_axi_awaddr = 16'h0000;
  logic [15:0]       s_axi_araddr = 16'h0000;
  logic [31:0]       s_axi_wdata = 32'h0000_0000;
  logic [3:0]        s_axi_wstrb = 4'h0;
  logic              s_axi_awvalid = 1'b0;
  logic              s_axi_wvalid = 1'b0;
  logic              s_axi_bready = 1'b0;
  logic              s_axi_arvalid = 1'b0;
  logic              s_axi_rready = 1'b0;
  logic              oscFail = 1'b0;
  logic [7:0]        extOe = 8'h00;
  logic [7:0]        extVal = 8'h00;
  logic              s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic              s_axi_arready, s_axi_rvalid;
  logic [1:0]        s_axi_bresp, s_axi_rresp;
  logic [31:0]       s_axi_rdata;
  logic [7:0]        pinIn, pinOut, pinOe, periphIn;
  int                badCount = 0;
  int                samplesChecked = 0;
  int                cycleCount = 0;

  always #2.5 sys_clk = ~sys_clk;

  pgo_port i_dut (
    .sys_clk(sys_clk), .reset_n(reset_n),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .oscillation_failure_reset(oscFail),
    .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe), .periphIn(periphIn)
  );

  pgo_pin_model i_pins (
    .pinOut(pinOut), .pinOe(pinOe), .extOe(extOe), .extVal(extVal),
    .pinIn(pinIn)
  );

  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    samplesChecked++;
    if (seen !== exp)
    begin
      badCount++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic axi_write(input logic [15:0] a, input logic [31:0] d,
                           input logic [3:0] s, output logic [1:0] r);
    @(posedge sys_clk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do
    begin
      @(posedge sys_clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      r = s_axi_bresp;
    end while (!(s_axi_bready && s_axi_bvalid));
    s_axi_bready <= 1'b0;
  endtask

  task automatic axi_read(input logic [15:0] a, output logic [31:0] d,
                          output logic [1:0] r);
    @(posedge sys_clk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do
    begin
      @(posedge sys_clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      d = s_axi_rdata;
      r = s_axi_rresp;
    end while (!(s_axi_rready && s_axi_rvalid));
    s_axi_rready <= 1'b0;
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    logic [1:0] r;
    axi_write(a, {24'h000000, d}, 4'h1, r);
  endtask

  task automatic rd_chk(input string name, input logic [15:0] a,
                        input logic [7:0] exp);
    logic [31:0] d;
    logic [1:0]  r;
    axi_read(a, d, r);
    check(name, d, {24'h000000, exp});
    check("rresp", r, RESP_OKAY);
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask

  task automatic set_port(input logic [7:0] od, input logic [7:0] dir,
                          input logic [7:0] lat, input logic [7:0] eo,
                          input logic [7:0] ev);
    @(posedge sys_clk);
    extOe  <= eo;
    extVal <= ev;
    wr(ADDR_OPENDR, od);
    wr(ADDR_LATCH, lat);
    wr(ADDR_DIR, dir);
    settle(3);
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic test_reset;
    settle(2);
    check("pinOe", pinOe, 8'h00);
    rd_chk("dir", ADDR_DIR, 8'h00);
    rd_chk("opendr", ADDR_OPENDR, 8'h00);
    rd_chk("pins", ADDR_LATCH, 8'hFF);
    check("periphIn", periphIn, 8'hFF);
    wr(ADDR_DIR, 8'hFF);
    settle(0);
    check("pinOut", pinOut, 8'h00);
    $display("test reset done");
  endtask

  task automatic test_push_pull;
    // bit 7 output, as the timer pin needs for plain timer use
    set_port(8'h00, 8'hF0, 8'hA5, 8'h0F, 8'h0C);
    check("pinOe", pinOe, 8'hF0);
    check("pinOut", pinOut & 8'hF0, 8'hA0);
    rd_chk("plain", ADDR_LATCH, 8'hAC);
    rd_chk("rmw", ADDR_RMW_VIEW, 8'hAC);
    check("periphIn", periphIn, 8'hAC);
    $display("test push-pull done");
  endtask

  task automatic test_open_drain;
    set_port(8'hFF, 8'h33, 8'h0F, 8'h03, 8'h00);
    check("pinOe", pinOe, 8'hF0);
    check("pinOut", pinOut, 8'h00);
    rd_chk("plain", ADDR_LATCH, 8'h0C);
    rd_chk("rmw", ADDR_RMW_VIEW, 8'h0F);
    check("periphIn", periphIn, 8'h0C);
    rd_chk("opendr", ADDR_OPENDR, 8'hFF);
    set_port(8'h0F, 8'hFF, 8'h5A, 8'h00, 8'h00);
    check("pinOe", pinOe, 8'hF5);
    check("pinOut", pinOut, 8'h50);
    rd_chk("plain", ADDR_LATCH, 8'h5A);
    $display("test open-drain done");
  endtask

  task automatic test_walk;
    set_port(8'h00, 8'h00, 8'hFF, 8'h00, 8'h00);
    for (int i = 0; i < 8; i++)
    begin
      wr(ADDR_DIR, 8'h01 << i);
      settle(0);
      check("pinOe", pinOe, 8'h01 << i);
    end
    $display("test walk done");
  endtask

  task automatic test_osc;
    set_port(8'h00, 8'hFF, 8'h3C, 8'h00, 8'h00);
    @(posedge sys_clk);
    oscFail <= 1'b1;
    settle(1);
    check("pinOe", pinOe, 8'h00);
    rd_chk("dir", ADDR_DIR, 8'hFF);
    @(posedge sys_clk);
    oscFail <= 1'b0;
    settle(1);
    check("pinOe", pinOe, 8'hFF);
    $display("test oscillation failure done");
  endtask

  task automatic test_errors;
    logic [1:0]  r;
    logic [31:0] d;
    axi_write(16'h0200, 32'h0000_00FF, 4'h1, r);
    check("bresp", r, RESP_SLVERR);
    axi_write(ADDR_RMW_VIEW, 32'h0000_00FF, 4'h1, r);
    check("bresp", r, RESP_SLVERR);
    axi_read(16'h0200, d, r);
    check("rresp", r, RESP_SLVERR);
    axi_write(ADDR_LATCH, 32'h0000_00FF, 4'h0, r);
    check("bresp", r, RESP_OKAY);
    rd_chk("latch", ADDR_LATCH, 8'h3C);
    $display("test errors done");
  endtask

  // ****************************************************************
  // verdict, timeout and main sequence
  // ****************************************************************
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", samplesChecked, badCount);
    if (badCount == 0 && samplesChecked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  always @(posedge sys_clk)
  begin
    cycleCount <= cycleCount + 1;
    if (cycleCount == 20000)
    begin
      badCount++;
      print_verdict();
    end
  end

  initial
  begin
    repeat (2) @(posedge sys_clk);
    reset_n <= 1'b1;
    test_reset();
    test_push_pull();
    test_open_drain();
    test_walk();
    test_osc();
    test_errors();
    print_verdict();
  end
endmodule
